// ==== design/cspp_params.svh ====
// Timing constants for the special-instruction pipeline sequencer
`ifndef CSPP_PARAMS_SVH
`define CSPP_PARAMS_SVH
`define CSPP_LIST_W 12
`define CSPP_CNT_W 5
`define CSPP_BIT_WAIT 3
`define CSPP_BIT_MEMS 2
`define CSPP_BIT_TEST_MEMS 1
`define CSPP_ID2_CYCLES 1
`define CSPP_SYSREG_WAIT 2
`define CSPP_TRAP_CODE_HI 8'h04
`define CSPP_TRAP_CODE_HI2 8'h05
`define CSPP_DISCARD_ONE 2'h1
`define CSPP_DISCARD_TWO 2'h2
`define CSPP_STAGES_TCALL 3'h6
`define CSPP_STAGES_TJUMP 3'h7
`endif

// ==== design/cspp_pkg.sv ====
// Types for the special-instruction pipeline sequencer
package cspp_pkg;
   typedef enum logic [4:0] {
      CSPP_OP_OTHER, CSPP_OP_BIT_CLEAR, CSPP_OP_BIT_INVERT, CSPP_OP_BIT_SET,
      CSPP_OP_BIT_TEST, CSPP_OP_TABLE_CALL, CSPP_OP_TABLE_CALL_RET, CSPP_OP_INT_DISABLE,
      CSPP_OP_INT_ENABLE, CSPP_OP_FRAME_RESTORE, CSPP_OP_FRAME_CREATE, CSPP_OP_HALT,
      CSPP_OP_SYSREG_WRITE, CSPP_OP_SYSREG_READ, CSPP_OP_NOP, CSPP_OP_EXC_RETURN,
      CSPP_OP_SW_TRAP, CSPP_OP_DBG_RETURN, CSPP_OP_DBG_TRAP, CSPP_OP_TABLE_JUMP,
      CSPP_OP_SHORT_LOAD, CSPP_OP_COND_BRANCH
   } cspp_op_e;
   typedef enum logic [2:0] {
      CSPP_ST_IDLE, CSPP_ST_BIT, CSPP_ST_FRAME, CSPP_ST_HALT, CSPP_ST_ID2,
      CSPP_ST_SYSWAIT, CSPP_ST_TJUMP
   } cspp_state_e;
endpackage

// ==== design/cspp_popcount.sv ====
// Counts selected registers in the register list field
`timescale 1ns/1ps
`include "cspp_params.svh"
module cspp_popcount (
   input wire logic [`CSPP_LIST_W-1:0] list_in,
   output logic [`CSPP_CNT_W-1:0] count_out
);
   always_comb begin
      count_out = '0;
      for (int i = 0; i < `CSPP_LIST_W; i++) begin
         count_out = count_out + {{(`CSPP_CNT_W-1){1'b0}}, list_in[i]};
      end
   end
endmodule

// ==== design/cspp_seq.sv ====
// Decode-stage sequencer and stall control for special instructions
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "cspp_params.svh"
module cspp_seq (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic ID_VALID,
   input wire cspp_pkg::cspp_op_e ID_OP,
   input wire logic [`CSPP_LIST_W-1:0] ID_LIST,
   input wire logic ID_BRANCH,
   input wire logic ID_SAVED_PC,
   input wire logic ID_IS16,
   input wire logic [15:0] ID_TRAP_CODE,
   input wire logic HALT_RELEASE,
   input wire logic INT_REQ,
   output logic ID_STALL,
   output logic MEM_REQ,
   output logic MEM_WRITE,
   output logic EX_ACTIVE,
   output logic WB_WRITE,
   output logic FETCH_DISCARD,
   output logic [1:0] DISCARD_COUNT,
   output logic FETCH_REDIRECT,
   output logic INT_ACCEPT,
   output logic PAIR_ALLOW,
   output logic TRAP_VECTOR_VALID,
   output logic HALTED
);
   // ----------------------------------------------------------------
   // Reset and input synchronisation
   // ----------------------------------------------------------------
   logic rst_a_q;
   logic rst_b_q;
   logic rst_n;
   logic hr_a_q;
   logic hr_b_q;
   logic ir_a_q;
   logic ir_b_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end
   assign rst_n = rst_b_q;
   // Halt release and interrupt arrive from outside the clock domain
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         hr_a_q <= 1'b0;
         hr_b_q <= 1'b0;
         ir_a_q <= 1'b0;
         ir_b_q <= 1'b0;
      end else begin
         hr_a_q <= HALT_RELEASE;
         hr_b_q <= hr_a_q;
         ir_a_q <= INT_REQ;
         ir_b_q <= ir_a_q;
      end
   end
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      cspp_pkg::cspp_state_e st;
      cspp_pkg::cspp_op_e op;
      logic [`CSPP_CNT_W-1:0] cnt;
      logic branch;
      logic last_sp_write;
      logic stall;
      logic mem_req;
      logic mem_write;
      logic ex_active;
      logic wb_write;
      logic discard;
      logic [1:0] discard_cnt;
      logic redirect;
      logic int_accept;
      logic pair;
      logic vec_valid;
      logic halted;
      logic rmw_pend;
   } cspp_state_s;
   cspp_state_s s_q;
   cspp_state_s s_d;
   logic [`CSPP_CNT_W-1:0] list_n;
   logic trap_code_ok;
   logic int_maskop;
   cspp_popcount u_popcount (
      .list_in(ID_LIST),
      .count_out(list_n)
   );
   // Only 004n and 005n codes are software traps
   assign trap_code_ok = (ID_TRAP_CODE[15:4] == 12'(`CSPP_TRAP_CODE_HI)) ||
      (ID_TRAP_CODE[15:4] == 12'(`CSPP_TRAP_CODE_HI2));
   // Interrupts are never taken on the mask-changing instruction itself
   assign int_maskop = (ID_OP == cspp_pkg::CSPP_OP_INT_DISABLE) ||
      (ID_OP == cspp_pkg::CSPP_OP_INT_ENABLE);
   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.mem_req = 1'b0;
      s_d.mem_write = 1'b0;
      s_d.ex_active = 1'b0;
      s_d.wb_write = 1'b0;
      s_d.discard = 1'b0;
      s_d.discard_cnt = 2'h0;
      s_d.redirect = 1'b0;
      s_d.int_accept = 1'b0;
      s_d.pair = 1'b0;
      s_d.vec_valid = 1'b0;
      s_d.rmw_pend = 1'b0;
      unique case (s_q.st)
         cspp_pkg::CSPP_ST_IDLE: begin
            s_d.stall = 1'b0;
            if (ID_VALID) begin
               s_d.op = ID_OP;
               s_d.last_sp_write = 1'b0;
               s_d.int_accept = ir_b_q && !int_maskop;
               unique case (ID_OP)
                  cspp_pkg::CSPP_OP_BIT_CLEAR, cspp_pkg::CSPP_OP_BIT_INVERT,
                  cspp_pkg::CSPP_OP_BIT_SET, cspp_pkg::CSPP_OP_BIT_TEST: begin
                     s_d.st = cspp_pkg::CSPP_ST_BIT;
                     s_d.cnt = `CSPP_CNT_W'(`CSPP_BIT_WAIT);
                     s_d.stall = 1'b1;
                     s_d.ex_active = 1'b1;
                  end
                  cspp_pkg::CSPP_OP_TABLE_CALL: begin
                     s_d.mem_req = 1'b1;
                     s_d.discard = 1'b1;
                     s_d.discard_cnt = `CSPP_DISCARD_ONE;
                  end
                  cspp_pkg::CSPP_OP_TABLE_CALL_RET: begin
                     // Target known in decode; later stages stay idle
                     s_d.discard = 1'b1;
                     s_d.discard_cnt = `CSPP_DISCARD_ONE;
                     s_d.redirect = 1'b1;
                  end
                  cspp_pkg::CSPP_OP_FRAME_RESTORE, cspp_pkg::CSPP_OP_FRAME_CREATE: begin
                     s_d.st = cspp_pkg::CSPP_ST_FRAME;
                     s_d.cnt = list_n;
                     s_d.branch = ID_BRANCH && (ID_OP == cspp_pkg::CSPP_OP_FRAME_RESTORE);
                     s_d.discard = s_d.branch;
                     s_d.discard_cnt = s_d.branch ? `CSPP_DISCARD_ONE : 2'h0;
                     s_d.stall = 1'b1;
                     s_d.ex_active = 1'b1;
                  end
                  cspp_pkg::CSPP_OP_HALT: begin
                     s_d.st = cspp_pkg::CSPP_ST_HALT;
                     s_d.stall = 1'b1;
                     s_d.halted = 1'b1;
                  end
                  cspp_pkg::CSPP_OP_SYSREG_WRITE: begin
                     s_d.last_sp_write = ID_SAVED_PC;
                     s_d.ex_active = 1'b1;
                     s_d.wb_write = 1'b1;
                  end
                  cspp_pkg::CSPP_OP_SYSREG_READ: begin
                     s_d.ex_active = 1'b1;
                     s_d.wb_write = 1'b1;
                     if (s_q.last_sp_write) begin
                        s_d.st = cspp_pkg::CSPP_ST_SYSWAIT;
                        s_d.cnt = `CSPP_CNT_W'(`CSPP_SYSREG_WAIT);
                        s_d.stall = 1'b1;
                        s_d.ex_active = 1'b0;
                        s_d.wb_write = 1'b0;
                     end
                  end
                  cspp_pkg::CSPP_OP_EXC_RETURN, cspp_pkg::CSPP_OP_SW_TRAP,
                  cspp_pkg::CSPP_OP_DBG_RETURN, cspp_pkg::CSPP_OP_DBG_TRAP: begin
                     // First decode cycle: register select or code detection
                     s_d.st = cspp_pkg::CSPP_ST_ID2;
                     s_d.stall = 1'b1;
                     s_d.discard = 1'b1;
                     s_d.discard_cnt = `CSPP_DISCARD_TWO;
                     if (ID_OP == cspp_pkg::CSPP_OP_SW_TRAP && !trap_code_ok) begin
                        s_d.st = cspp_pkg::CSPP_ST_IDLE;
                        s_d.stall = 1'b0;
                        s_d.discard = 1'b0;
                        s_d.discard_cnt = 2'h0;
                     end
                  end
                  cspp_pkg::CSPP_OP_TABLE_JUMP: begin
                     s_d.st = cspp_pkg::CSPP_ST_TJUMP;
                     s_d.cnt = `CSPP_CNT_W'(1);
                     s_d.stall = 1'b1;
                     s_d.ex_active = 1'b1;
                     s_d.discard = 1'b1;
                     s_d.discard_cnt = `CSPP_DISCARD_ONE;
                  end
                  cspp_pkg::CSPP_OP_SHORT_LOAD, cspp_pkg::CSPP_OP_COND_BRANCH: begin
                     // Pairing may hide a following no-operation delay
                     s_d.pair = ID_IS16;
                     s_d.mem_req = (ID_OP == cspp_pkg::CSPP_OP_SHORT_LOAD);
                  end
                  cspp_pkg::CSPP_OP_NOP: begin
                     s_d.ex_active = 1'b0;
                  end
                  default: begin
                     s_d.ex_active = 1'b1;
                  end
               endcase
            end else begin
               // A decode bubble means the read no longer follows the write
               s_d.last_sp_write = 1'b0;
            end
         end
         cspp_pkg::CSPP_ST_BIT: begin
            s_d.cnt = s_q.cnt - `CSPP_CNT_W'(1);
            s_d.mem_req = (s_q.cnt == `CSPP_CNT_W'(`CSPP_BIT_WAIT));
            s_d.ex_active = (s_q.cnt == `CSPP_CNT_W'(2));
            if (s_q.cnt == `CSPP_CNT_W'(2)) begin
               s_d.stall = 1'b0;
               s_d.st = cspp_pkg::CSPP_ST_IDLE;
               // Bit test has no write pass; its second memory slot stays idle
               s_d.rmw_pend = (s_q.op != cspp_pkg::CSPP_OP_BIT_TEST);
            end
         end
         cspp_pkg::CSPP_ST_FRAME: begin
            s_d.mem_req = 1'b1;
            s_d.mem_write = (s_q.op == cspp_pkg::CSPP_OP_FRAME_CREATE);
            s_d.cnt = s_q.cnt - `CSPP_CNT_W'(1);
            if (s_q.cnt == '0) begin
               s_d.st = cspp_pkg::CSPP_ST_IDLE;
               s_d.stall = 1'b0;
               s_d.redirect = s_q.branch;
               s_d.wb_write = 1'b1;
            end
         end
         cspp_pkg::CSPP_ST_HALT: begin
            if (hr_b_q) begin
               s_d.st = cspp_pkg::CSPP_ST_IDLE;
               s_d.stall = 1'b0;
               s_d.halted = 1'b0;
            end
         end
         cspp_pkg::CSPP_ST_ID2: begin
            // Second decode cycle: saved PC read or handler address built
            s_d.st = cspp_pkg::CSPP_ST_IDLE;
            s_d.stall = 1'b0;
            s_d.ex_active = 1'b1;
            s_d.redirect = 1'b1;
            s_d.vec_valid = (s_q.op == cspp_pkg::CSPP_OP_SW_TRAP) ||
               (s_q.op == cspp_pkg::CSPP_OP_DBG_TRAP);
            s_d.mem_req = 1'b0;
         end
         cspp_pkg::CSPP_ST_SYSWAIT: begin
            s_d.cnt = s_q.cnt - `CSPP_CNT_W'(1);
            if (s_q.cnt == `CSPP_CNT_W'(1)) begin
               s_d.st = cspp_pkg::CSPP_ST_IDLE;
               s_d.stall = 1'b0;
               s_d.ex_active = 1'b1;
               s_d.wb_write = 1'b1;
               s_d.last_sp_write = 1'b0;
            end
         end
         cspp_pkg::CSPP_ST_TJUMP: begin
            // Memory read then second execute; trailing slots idle
            s_d.cnt = s_q.cnt - `CSPP_CNT_W'(1);
            s_d.mem_req = (s_q.cnt == `CSPP_CNT_W'(1));
            if (s_q.cnt == '0) begin
               s_d.ex_active = 1'b1;
               s_d.redirect = 1'b1;
               s_d.stall = 1'b0;
               s_d.st = cspp_pkg::CSPP_ST_IDLE;
            end
         end
         default: begin
            s_d.st = cspp_pkg::CSPP_ST_IDLE;
            s_d.stall = 1'b0;
         end
      endcase
      // Write pass overlaps the next decode; a load issued in that
      // same cycle would have to share the bus slot
      if (s_q.rmw_pend) begin
         s_d.mem_req = 1'b1;
         s_d.mem_write = 1'b1;
      end
   end
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ID_STALL = s_q.stall;
   assign MEM_REQ = s_q.mem_req;
   assign MEM_WRITE = s_q.mem_write;
   assign EX_ACTIVE = s_q.ex_active;
   assign WB_WRITE = s_q.wb_write;
   assign FETCH_DISCARD = s_q.discard;
   assign DISCARD_COUNT = s_q.discard_cnt;
   assign FETCH_REDIRECT = s_q.redirect;
   assign INT_ACCEPT = s_q.int_accept;
   assign PAIR_ALLOW = s_q.pair;
   assign TRAP_VECTOR_VALID = s_q.vec_valid;
   assign HALTED = s_q.halted;
endmodule

// ==== test/cspp_mem_model.sv ====
// Counting model of the fetch path and data-memory bus
`timescale 1ns/1ps
module cspp_mem_model (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic MEM_REQ,
   input wire logic MEM_WRITE,
   input wire logic FETCH_DISCARD,
   input wire logic [1:0] DISCARD_COUNT,
   output logic [15:0] rd_cnt,
   output logic [15:0] wr_cnt,
   output logic [15:0] drop_cnt
);
   // ----------------------------------------
   // Zero-wait bus, so counts show raw demand
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_cnt <= 16'h0000;
         wr_cnt <= 16'h0000;
         drop_cnt <= 16'h0000;
      end else begin
         if (MEM_REQ && !MEM_WRITE) rd_cnt <= rd_cnt + 16'h0001;
         if (MEM_REQ && MEM_WRITE) wr_cnt <= wr_cnt + 16'h0001;
         if (FETCH_DISCARD) drop_cnt <= drop_cnt + {14'h0000, DISCARD_COUNT};
      end
   end
endmodule

// ==== test/cspp_seq_monitor.sv ====
// Checker of stall and pulse timing at the sequencer ports
`timescale 1ns/1ps
`include "cspp_params.svh"
module cspp_seq_monitor (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic ID_VALID,
   input wire cspp_pkg::cspp_op_e ID_OP,
   input wire logic [`CSPP_LIST_W-1:0] ID_LIST,
   input wire logic ID_BRANCH,
   input wire logic ID_SAVED_PC,
   input wire logic ID_IS16,
   input wire logic [15:0] ID_TRAP_CODE,
   input wire logic HALT_RELEASE,
   input wire logic INT_REQ,
   input wire logic ID_STALL,
   input wire logic MEM_REQ,
   input wire logic MEM_WRITE,
   input wire logic EX_ACTIVE,
   input wire logic WB_WRITE,
   input wire logic FETCH_DISCARD,
   input wire logic [1:0] DISCARD_COUNT,
   input wire logic FETCH_REDIRECT,
   input wire logic INT_ACCEPT,
   input wire logic PAIR_ALLOW,
   input wire logic TRAP_VECTOR_VALID,
   input wire logic HALTED
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking dc @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire logic tk = ID_VALID && !ID_STALL;
   wire logic rmw = tk && ID_OP inside {cspp_pkg::CSPP_OP_BIT_CLEAR,
      cspp_pkg::CSPP_OP_BIT_INVERT, cspp_pkg::CSPP_OP_BIT_SET};
   wire logic bt = tk && ID_OP == cspp_pkg::CSPP_OP_BIT_TEST;
   property p_bit_rmw; rmw |-> ##2 (MEM_REQ && !MEM_WRITE) ##2 (MEM_REQ && MEM_WRITE); endproperty
   a_bit_rmw: assert property (p_bit_rmw) else $error("bit op memory pass wrong");
   property p_bit_test; bt |-> ##2 (MEM_REQ && !MEM_WRITE) ##2 !MEM_REQ; endproperty
   a_bit_test: assert property (p_bit_test) else $error("bit test memory pass wrong");
   property p_bit_hold; rmw || bt |=> ID_STALL [*2] ##1 !ID_STALL; endproperty
   a_bit_hold: assert property (p_bit_hold) else $error("bit op decode hold wrong");
   property p_tcall;
      tk && ID_OP == cspp_pkg::CSPP_OP_TABLE_CALL |=> MEM_REQ && FETCH_DISCARD && DISCARD_COUNT == 2'h1;
   endproperty
   a_tcall: assert property (p_tcall) else $error("table call start wrong");
   property p_int_mask;
      tk && ID_OP inside {cspp_pkg::CSPP_OP_INT_DISABLE, cspp_pkg::CSPP_OP_INT_ENABLE} |=> !INT_ACCEPT;
   endproperty
   a_int_mask: assert property (p_int_mask) else $error("interrupt taken on mask op");
   property p_sys;
      (tk && ID_OP == cspp_pkg::CSPP_OP_SYSREG_WRITE && ID_SAVED_PC)
         ##1 (tk && ID_OP == cspp_pkg::CSPP_OP_SYSREG_READ) |=> ID_STALL [*2] ##1 !ID_STALL;
   endproperty
   a_sys: assert property (p_sys) else $error("sysreg read wait wrong");
   property p_two_drop;
      tk && ID_OP inside {cspp_pkg::CSPP_OP_EXC_RETURN, cspp_pkg::CSPP_OP_DBG_RETURN,
         cspp_pkg::CSPP_OP_DBG_TRAP} |-> ##[1:3] (FETCH_DISCARD && DISCARD_COUNT == 2'h2);
   endproperty
   a_two_drop: assert property (p_two_drop) else $error("double fetch drop missing");
   property p_quiet;
      tk && ID_OP == cspp_pkg::CSPP_OP_NOP
         |=> !(MEM_REQ || EX_ACTIVE || WB_WRITE || FETCH_DISCARD || ID_STALL);
   endproperty
   a_quiet: assert property (p_quiet) else $error("no-operation did work");
   c_bit: cover property (rmw);
   c_frame_br: cover property (tk && ID_OP == cspp_pkg::CSPP_OP_FRAME_RESTORE && ID_BRANCH);
   c_halt: cover property (HALTED ##1 !HALTED);
endmodule
bind cspp_seq cspp_seq_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .ID_VALID(ID_VALID),
   .ID_OP(ID_OP), .ID_LIST(ID_LIST), .ID_BRANCH(ID_BRANCH), .ID_SAVED_PC(ID_SAVED_PC),
   .ID_IS16(ID_IS16), .ID_TRAP_CODE(ID_TRAP_CODE), .HALT_RELEASE(HALT_RELEASE),
   .INT_REQ(INT_REQ), .ID_STALL(ID_STALL), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
   .EX_ACTIVE(EX_ACTIVE), .WB_WRITE(WB_WRITE), .FETCH_DISCARD(FETCH_DISCARD),
   .DISCARD_COUNT(DISCARD_COUNT), .FETCH_REDIRECT(FETCH_REDIRECT), .INT_ACCEPT(INT_ACCEPT),
   .PAIR_ALLOW(PAIR_ALLOW), .TRAP_VECTOR_VALID(TRAP_VECTOR_VALID), .HALTED(HALTED));

// ==== test/tb_top.sv ====
// Random and corner-case bench for the special-instruction sequencer
`timescale 1ns/1ps
`include "cspp_params.svh"
module tb_top;
   logic CLK, RESET_N, ID_VALID, ID_BRANCH, ID_SAVED_PC, ID_IS16, HALT_RELEASE, INT_REQ;
   logic ID_STALL, MEM_REQ, MEM_WRITE, EX_ACTIVE, WB_WRITE, FETCH_DISCARD, FETCH_REDIRECT;
   logic INT_ACCEPT, PAIR_ALLOW, TRAP_VECTOR_VALID, HALTED;
   logic [1:0] DISCARD_COUNT;
   logic [`CSPP_LIST_W-1:0] ID_LIST;
   logic [15:0] ID_TRAP_CODE, rd_cnt, wr_cnt, drop_cnt, h0;
   logic [31:0] seed;
   logic [7:0] s;
   cspp_pkg::cspp_op_e ID_OP, rop;
   int n_fail = 0;
   int check_count = 0;
   string nm [10] = '{"mem", "mem_write", "ex", "wb", "drop", "redirect", "stall", "trap_vec",
      "pair", "int_accept"};
   cspp_seq uut (.CLK(CLK), .RESET_N(RESET_N), .ID_VALID(ID_VALID), .ID_OP(ID_OP),
      .ID_LIST(ID_LIST), .ID_BRANCH(ID_BRANCH), .ID_SAVED_PC(ID_SAVED_PC), .ID_IS16(ID_IS16),
      .ID_TRAP_CODE(ID_TRAP_CODE), .HALT_RELEASE(HALT_RELEASE), .INT_REQ(INT_REQ),
      .ID_STALL(ID_STALL), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .EX_ACTIVE(EX_ACTIVE),
      .WB_WRITE(WB_WRITE), .FETCH_DISCARD(FETCH_DISCARD), .DISCARD_COUNT(DISCARD_COUNT),
      .FETCH_REDIRECT(FETCH_REDIRECT), .INT_ACCEPT(INT_ACCEPT), .PAIR_ALLOW(PAIR_ALLOW),
      .TRAP_VECTOR_VALID(TRAP_VECTOR_VALID), .HALTED(HALTED));
   cspp_mem_model u_mem (.CLK(CLK), .RESET_N(RESET_N), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
      .FETCH_DISCARD(FETCH_DISCARD), .DISCARD_COUNT(DISCARD_COUNT), .rd_cnt(rd_cnt),
      .wr_cnt(wr_cnt), .drop_cnt(drop_cnt));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Byte FF marks a count left open for that class
   function automatic logic [9:0][7:0] expect_of(input cspp_pkg::cspp_op_e op,
      input logic [11:0] l, input logic br, input logic s16, input logic [15:0] c, input logic irq);
      logic [9:0][7:0] e;
      logic [7:0] n;
      e = '1;
      n = 8'($countones(l)) + 8'h01;
      case (op)
         cspp_pkg::CSPP_OP_BIT_CLEAR, cspp_pkg::CSPP_OP_BIT_INVERT, cspp_pkg::CSPP_OP_BIT_SET:
            e[6:0] = {8'h02, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h01, 8'h02};
         cspp_pkg::CSPP_OP_BIT_TEST: e[6:0] = {8'h02, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01};
         cspp_pkg::CSPP_OP_TABLE_CALL: e[4:0] = {8'h01, 8'h00, 8'hFF, 8'h00, 8'h01};
         cspp_pkg::CSPP_OP_TABLE_CALL_RET: e[5:0] = {8'h01, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00};
         cspp_pkg::CSPP_OP_INT_DISABLE, cspp_pkg::CSPP_OP_INT_ENABLE: begin
            e[9] = 8'h00;
            e[3:0] = {8'h00, 8'hFF, 8'hFF, 8'h00};
         end
         cspp_pkg::CSPP_OP_FRAME_RESTORE: e[5:0] = {{7'h00, br}, {7'h00, br}, 16'hFFFF, 8'h00, n};
         cspp_pkg::CSPP_OP_FRAME_CREATE: e[1:0] = {n, n};
         cspp_pkg::CSPP_OP_NOP: e = {{7'h00, irq}, 72'h0};
         cspp_pkg::CSPP_OP_EXC_RETURN, cspp_pkg::CSPP_OP_DBG_RETURN:
            e[6:0] = {8'h01, 8'h01, 8'h02, 8'h00, 8'hFF, 8'hFF, 8'h00};
         cspp_pkg::CSPP_OP_DBG_TRAP: e[6:4] = {8'h01, 8'h01, 8'h02};
         cspp_pkg::CSPP_OP_SW_TRAP: begin
            if (c[15:5] == 11'h002) e[7:4] = {8'h01, 8'h01, 8'h01, 8'h02};
            else e[8:0] = '0;
         end
         cspp_pkg::CSPP_OP_TABLE_JUMP: e[3:0] = {8'h00, 8'hFF, 8'h00, 8'h01};
         cspp_pkg::CSPP_OP_SHORT_LOAD, cspp_pkg::CSPP_OP_COND_BRANCH: e[8] = {7'h00, s16};
         default: ;
      endcase
      return e;
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One decode slot, then a quiet window long enough for a full list
   task automatic run_op(input cspp_pkg::cspp_op_e op, input logic [11:0] l, input logic br,
      input logic s16, input logic [15:0] c, input logic irq);
      logic [9:0][7:0] g;
      logic [9:0][7:0] e;
      logic [15:0] r0, w0, d0;
      INT_REQ = irq;
      repeat (4) @(negedge CLK);
      ID_OP = op;
      {ID_LIST, ID_BRANCH, ID_IS16, ID_TRAP_CODE, ID_VALID} = {l, br, s16, c, 1'b1};
      {r0, w0, d0} = {rd_cnt, wr_cnt, drop_cnt};
      g = '0;
      @(negedge CLK);
      ID_VALID = 1'b0;
      repeat (24) begin
         g[2] += 8'(EX_ACTIVE);
         g[3] += 8'(WB_WRITE);
         g[5] += 8'(FETCH_REDIRECT);
         g[6] += 8'(ID_STALL);
         g[7] += 8'(TRAP_VECTOR_VALID);
         g[8] += 8'(PAIR_ALLOW);
         g[9] += 8'(INT_ACCEPT);
         @(negedge CLK);
      end
      g[1:0] = {8'(wr_cnt - w0), 8'(rd_cnt - r0 + wr_cnt - w0)};
      g[4] = 8'(drop_cnt - d0);
      e = expect_of(op, l, br, s16, c, irq);
      for (int i = 0; i < 10; i++) begin
         if (e[i] !== 8'hFF) chk(nm[i], e[i], g[i]);
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {RESET_N, ID_VALID, ID_BRANCH, ID_SAVED_PC, ID_IS16, HALT_RELEASE, INT_REQ} = '0;
      ID_OP = cspp_pkg::CSPP_OP_OTHER;
      {ID_LIST, ID_TRAP_CODE} = '0;
      seed = 32'hE0C4;
      repeat (8) @(negedge CLK);
      RESET_N = 1'b1;
      for (int k = 1; k < 22; k++) begin
         if (k != 11) run_op(cspp_pkg::cspp_op_e'(k), 12'hFFF, 1'b1, 1'b1, 16'h0040, 1'b1);
      end
      run_op(cspp_pkg::CSPP_OP_FRAME_RESTORE, 12'h000, 1'b0, 1'b0, 16'h0000, 1'b0);
      run_op(cspp_pkg::CSPP_OP_FRAME_CREATE, 12'h001, 1'b0, 1'b0, 16'h0000, 1'b0);
      run_op(cspp_pkg::CSPP_OP_SW_TRAP, 12'h000, 1'b0, 1'b0, 16'h005F, 1'b0);
      run_op(cspp_pkg::CSPP_OP_SW_TRAP, 12'h000, 1'b0, 1'b0, 16'h0060, 1'b0);
      run_op(cspp_pkg::CSPP_OP_SW_TRAP, 12'h000, 1'b0, 1'b0, 16'h003F, 1'b0);
      run_op(cspp_pkg::CSPP_OP_SHORT_LOAD, 12'h000, 1'b0, 1'b0, 16'h0000, 1'b0);
      repeat (40) begin
         seed = xs(seed);
         rop = cspp_pkg::cspp_op_e'(seed[31:27] % 5'd22);
         if (rop == cspp_pkg::CSPP_OP_HALT) rop = cspp_pkg::CSPP_OP_NOP;
         run_op(rop, seed[11:0], seed[12], seed[13],
            seed[14] ? {8'h00, seed[23:16]} : {11'h002, seed[20:16]}, seed[15]);
      end
      for (int k = 0; k < 2; k++) begin
         repeat (4) @(negedge CLK);
         ID_OP = cspp_pkg::CSPP_OP_SYSREG_WRITE;
         {ID_VALID, ID_SAVED_PC} = {1'b1, k[0]};
         @(negedge CLK);
         ID_OP = cspp_pkg::CSPP_OP_SYSREG_READ;
         @(negedge CLK);
         ID_VALID = 1'b0;
         s = 8'h00;
         repeat (6) begin
            s += 8'(ID_STALL);
            @(negedge CLK);
         end
         chk("stall", {6'h00, k[0], 1'b0}, s);
      end
      ID_OP = cspp_pkg::CSPP_OP_HALT;
      ID_VALID = 1'b1;
      h0 = rd_cnt + wr_cnt;
      @(negedge CLK);
      ID_VALID = 1'b0;
      repeat (10) @(negedge CLK);
      chk("halted", 8'h01, 8'(HALTED));
      chk("stall", 8'h01, 8'(ID_STALL));
      chk("mem", 8'h00, 8'(rd_cnt + wr_cnt - h0));
      HALT_RELEASE = 1'b1;
      for (int t = 0; t < 10 && HALTED !== 1'b0; t++) @(negedge CLK);
      chk("halted", 8'h00, 8'(HALTED));
      HALT_RELEASE = 1'b0;
      test_done;
   end
   initial begin
      #100000;
      n_fail++;
      test_done;
   end
endmodule
